// ---- hw/program_flow_sequencer.sv ----
// program counter, call/return stack and interrupt entry/exit sequencer
//
// Contract
// - default: program counter advances by one
// - reset sets program counter to zero
// - conditions: carry set/clear, zero set/clear
// - no condition means always execute
// - untaken jump: two cycles, next instruction
// - taken jump loads absolute target address
// - jump leaves stack and flags alone
// - taken call pushes pc, loads target
// - untaken call pushes nothing, changes nothing
// - taken return pops, adds one, loads
// - call and return never change flags
// - one interrupt input, disabled after reset
// - finish instruction, then call last location
// - entry saves flags, disables, pushes pc
// - acknowledge only in second event cycle
// - isr return restores pc and flags
// - isr return enable and disable variants
// - isr return does not increment popped value
// - vector is all address bits one
module program_flow_sequencer #(
  parameter int STACK_DEPTH = flow_seq_pkg::STACK_DEPTH_DEF
) (
  input  wire logic                              i_clk,
  input  wire logic                              i_rst,
  input  wire flow_seq_pkg::instr_type           i_instr,
  input  wire logic                              i_flags_we,
  input  wire flow_seq_pkg::flags_type           i_alu_flags,
  input  wire logic                              i_interrupt,
  input  wire logic                              i_psel,
  input  wire logic                              i_penable,
  input  wire logic                              i_pwrite,
  input  wire logic [flow_seq_pkg::APB_AW-1:0]   i_paddr,
  input  wire logic [31:0]                       i_pwdata,
  output logic      [flow_seq_pkg::PC_W-1:0]     o_address,
  output logic                                   o_execute,
  output logic                                   o_interrupt_ack,
  output flow_seq_pkg::flags_type                o_flags,
  output logic      [31:0]                       o_prdata,
  output logic                                   o_pready,
  output logic                                   o_pslverr
);

  localparam int SP_W = $clog2(STACK_DEPTH);
  localparam int PW = flow_seq_pkg::PC_W;

  typedef enum logic [3:0] {
    st_decode   = 4'h1,
    st_execute  = 4'h2,
    st_int_save = 4'h4,
    st_int_ack  = 4'h8
  } state_type;

  state_type                state;
  state_type                next_state;
  logic      [PW-1:0]       stack_mem [STACK_DEPTH];
  logic      [SP_W-1:0]     sp;
  logic      [PW-1:0]       stack_top;
  logic      [PW-1:0]       next_pc;
  logic                     cond_ok;
  logic                     exec_flow;
  logic                     push_call;
  logic                     pop_ret;
  logic                     pop_reti;
  logic                     int_enable;
  logic                     int_sample;
  logic                     int_take;
  logic                     hold;
  logic                     in_isr;
  flow_seq_pkg::flags_type  saved_flags;
  logic                     apb_access;

  // condition evaluation, no condition means always true
  always_comb begin
    case (i_instr.cond)
      flow_seq_pkg::cond_always:      cond_ok = 1'b1;
      flow_seq_pkg::cond_carry_set:   cond_ok = o_flags.carry;
      flow_seq_pkg::cond_carry_clear: cond_ok = !o_flags.carry;
      flow_seq_pkg::cond_zero_set:    cond_ok = o_flags.zero;
      flow_seq_pkg::cond_zero_clear:  cond_ok = !o_flags.zero;
      default:                        cond_ok = 1'b0;
    endcase
  end

  // stack strobes, only in the execute cycle or the first event cycle
  assign exec_flow = (state == st_execute);
  assign push_call = exec_flow && (i_instr.op == flow_seq_pkg::op_call) && cond_ok;
  assign pop_ret   = exec_flow && (i_instr.op == flow_seq_pkg::op_return) && cond_ok;
  assign pop_reti  = exec_flow && (i_instr.op == flow_seq_pkg::op_return_from_isr);
  assign stack_top = stack_mem[SP_W'(sp - 1'b1)];
  // enable is judged before the current instruction's own enable takes effect
  assign int_take  = exec_flow && int_enable && int_sample;

  // next program counter at the end of an execute cycle
  always_comb begin
    next_pc = o_address + flow_seq_pkg::PC_STEP;
    case (i_instr.op)
      flow_seq_pkg::op_jump,
      flow_seq_pkg::op_call: begin
        if (cond_ok) begin
          next_pc = i_instr.target;
        end
      end
      flow_seq_pkg::op_return: begin
        if (cond_ok) begin
          next_pc = stack_top + flow_seq_pkg::PC_STEP;
        end
      end
      flow_seq_pkg::op_return_from_isr: begin
        next_pc = stack_top;
      end
      default: begin
        next_pc = o_address + flow_seq_pkg::PC_STEP;
      end
    endcase
  end

  // two-cycle instruction sequencing, with a two-cycle interrupt event
  always_comb begin
    case (state)
      st_decode:   next_state = hold ? st_decode : st_execute;
      st_execute:  next_state = int_take ? st_int_save : st_decode;
      st_int_save: next_state = st_int_ack;
      st_int_ack:  next_state = st_decode;
      default:     next_state = st_decode;
    endcase
  end

  // state register and the execute phase marker for the rest of the core
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state     <= st_decode;
      o_execute <= 1'b0;
    end else begin
      state     <= next_state;
      o_execute <= (next_state == st_execute);
    end
  end

  // program counter; during the event it still shows the preempted address
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_address <= flow_seq_pkg::PC_RESET;
    end else if (state == st_execute) begin
      o_address <= next_pc;
    end else if (state == st_int_ack) begin
      o_address <= flow_seq_pkg::INT_VECTOR;
    end
  end

  // stack pointer; overflow and underflow simply wrap
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sp <= '0;
    end else if (push_call || state == st_int_save) begin
      sp <= SP_W'(sp + 1'b1);
    end else if (pop_ret || pop_reti) begin
      sp <= SP_W'(sp - 1'b1);
    end
  end

  // stack storage needs no reset, entries are written before they are read
  always_ff @(posedge i_clk) begin
    if (push_call || state == st_int_save) begin
      stack_mem[sp] <= o_address;
    end
  end

  // one interrupt sample stage; a two-cycle request meets an execute cycle while hold is clear
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      int_sample <= 1'b0;
    end else begin
      int_sample <= i_interrupt;
    end
  end

  // interrupt enable
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      int_enable <= 1'b0;
    end else if (state == st_int_save) begin
      int_enable <= 1'b0;
    end else if (exec_flow) begin
      case (i_instr.op)
        flow_seq_pkg::op_int_enable:      int_enable <= 1'b1;
        flow_seq_pkg::op_int_disable:     int_enable <= 1'b0;
        flow_seq_pkg::op_return_from_isr: int_enable <= i_instr.reti_enable;
        default:                          int_enable <= int_enable;
      endcase
    end
  end

  // carry and zero; of the flow instructions only isr return writes them, from the saved copy
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_flags     <= flow_seq_pkg::FLAGS_RESET;
      saved_flags <= flow_seq_pkg::FLAGS_RESET;
    end else begin
      if (state == st_int_save) begin
        saved_flags <= o_flags;
      end
      if (pop_reti) begin
        o_flags <= saved_flags;
      end else if (exec_flow && i_flags_we && i_instr.op == flow_seq_pkg::op_seq) begin
        o_flags <= i_alu_flags;
      end
    end
  end

  // acknowledge pulse in the second event cycle; in_isr is status only
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_interrupt_ack <= 1'b0;
      in_isr          <= 1'b0;
    end else begin
      o_interrupt_ack <= (state == st_int_save);
      if (state == st_int_save) begin
        in_isr <= 1'b1;
      end else if (pop_reti) begin
        in_isr <= 1'b0;
      end
    end
  end

  // apb slave: answers one cycle into the access phase, unmapped gives slverr
  assign apb_access = i_psel && i_penable && !o_pready;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      hold      <= flow_seq_pkg::CTRL_HOLD_RESET;
    end else begin
      o_pready  <= apb_access;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      if (apb_access) begin
        case (i_paddr)
          flow_seq_pkg::CTRL_OFFSET: begin
            if (i_pwrite) begin
              hold <= i_pwdata[flow_seq_pkg::CTRL_HOLD_BIT];
            end else begin
              o_prdata[flow_seq_pkg::CTRL_HOLD_BIT] <= hold;
            end
          end
          flow_seq_pkg::STATUS_OFFSET: begin
            // read only: writes are accepted and dropped
            if (!i_pwrite) begin
              o_prdata[flow_seq_pkg::STAT_IE_BIT]          <= int_enable;
              o_prdata[flow_seq_pkg::STAT_CARRY_BIT]       <= o_flags.carry;
              o_prdata[flow_seq_pkg::STAT_ZERO_BIT]        <= o_flags.zero;
              o_prdata[flow_seq_pkg::STAT_SAVED_CARRY_BIT] <= saved_flags.carry;
              o_prdata[flow_seq_pkg::STAT_SAVED_ZERO_BIT]  <= saved_flags.zero;
              o_prdata[flow_seq_pkg::STAT_IN_ISR_BIT]      <= in_isr;
              o_prdata[flow_seq_pkg::STAT_SP_LSB +: SP_W]  <= sp;
            end
          end
          default: begin
            o_pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // checks ------------------------------------------------------------------

  sequence s_int_event;
    (state == st_int_save && !o_interrupt_ack) ##1
    (state == st_int_ack && o_interrupt_ack) ##1
    (o_address == flow_seq_pkg::INT_VECTOR && !o_interrupt_ack);
  endsequence

  sequence s_exec_is(flow_seq_pkg::flow_op_type op);
    state == st_execute && i_instr.op == op;
  endsequence

  property p_reset_pc;
    @(posedge i_clk) disable iff (i_rst)
    $past(i_rst) |-> (o_address == flow_seq_pkg::PC_RESET && !int_enable);
  endproperty
  a_reset_pc: assert property (p_reset_pc) else $error("bad state after reset");

  property p_seq_step;
    @(posedge i_clk) disable iff (i_rst)
    s_exec_is(flow_seq_pkg::op_seq) |=>
      o_address == PW'($past(o_address) + flow_seq_pkg::PC_STEP);
  endproperty
  a_seq_step: assert property (p_seq_step) else $error("pc did not advance by one");

  property p_jump_not_taken;
    @(posedge i_clk) disable iff (i_rst)
    (s_exec_is(flow_seq_pkg::op_jump) and (state == st_execute && !cond_ok)) |=>
      o_address == PW'($past(o_address) + flow_seq_pkg::PC_STEP) && $stable(sp);
  endproperty
  a_jump_not_taken: assert property (p_jump_not_taken) else $error("bad untaken jump");

  property p_jump_taken;
    @(posedge i_clk) disable iff (i_rst)
    (state == st_execute && i_instr.op == flow_seq_pkg::op_jump && cond_ok) |=>
      o_address == $past(i_instr.target) && $stable(sp) && $stable(o_flags);
  endproperty
  a_jump_taken: assert property (p_jump_taken) else $error("taken jump target wrong");

  property p_call_taken;
    @(posedge i_clk) disable iff (i_rst)
    push_call |=> sp == SP_W'($past(sp) + 1'b1) && stack_mem[$past(sp)] == $past(o_address)
      && o_address == $past(i_instr.target);
  endproperty
  a_call_taken: assert property (p_call_taken) else $error("taken call push wrong");

  property p_call_not_taken;
    @(posedge i_clk) disable iff (i_rst)
    (state == st_execute && i_instr.op == flow_seq_pkg::op_call && !cond_ok) |=>
      $stable(sp) && $stable(o_flags);
  endproperty
  a_call_not_taken: assert property (p_call_not_taken) else $error("bad untaken call");

  property p_return_taken;
    @(posedge i_clk) disable iff (i_rst)
    pop_ret |=> o_address == PW'($past(stack_top) + flow_seq_pkg::PC_STEP)
      && $stable(o_flags);
  endproperty
  a_return_taken: assert property (p_return_taken) else $error("return target wrong");

  property p_flow_flags;
    @(posedge i_clk) disable iff (i_rst)
    (state == st_execute && (i_instr.op == flow_seq_pkg::op_call
      || i_instr.op == flow_seq_pkg::op_return)) |=> $stable(o_flags);
  endproperty
  a_flow_flags: assert property (p_flow_flags) else $error("call or return set flags");

  property p_disabled_ignored;
    @(posedge i_clk) disable iff (i_rst)
    (state == st_execute && !int_enable) |=> state != st_int_save;
  endproperty
  a_disabled_ignored: assert property (p_disabled_ignored) else $error("masked irq");

  property p_int_entry;
    @(posedge i_clk) disable iff (i_rst)
    int_take |=> s_int_event;
  endproperty
  a_int_entry: assert property (p_int_entry) else $error("bad interrupt event");

  property p_int_save;
    @(posedge i_clk) disable iff (i_rst)
    (state == st_int_save) |=> !int_enable && saved_flags == $past(o_flags)
      && stack_mem[$past(sp)] == $past(o_address);
  endproperty
  a_int_save: assert property (p_int_save) else $error("interrupt entry save wrong");

  property p_ack_only_second;
    @(posedge i_clk) disable iff (i_rst)
    o_interrupt_ack |-> state == st_int_ack && $past(state) == st_int_save;
  endproperty
  a_ack_only_second: assert property (p_ack_only_second) else $error("stray ack");

  property p_reti;
    @(posedge i_clk) disable iff (i_rst)
    pop_reti |=> o_address == $past(stack_top) && o_flags == $past(saved_flags)
      && int_enable == $past(i_instr.reti_enable);
  endproperty
  a_reti: assert property (p_reti) else $error("isr return wrong");

endmodule

// ---- inc/flow_seq_pkg.sv ----
// shared types and constants for the program flow and interrupt sequencer
package flow_seq_pkg;

  // program address space: 1K instruction store
  localparam int PC_W = 10;
  localparam logic [PC_W-1:0] PC_RESET = 10'h000;
  localparam logic [PC_W-1:0] PC_STEP = 10'h001;
  // interrupt vector is the last implemented location, all address bits set
  localparam logic [PC_W-1:0] INT_VECTOR = {PC_W{1'b1}};

  // call/return stack depth default, a power of two so the pointer wraps
  localparam int STACK_DEPTH_DEF = 32;

  // instruction and interrupt event length in clock cycles
  localparam int INSTR_CYCLES = 2;

  // apb register map, byte addresses
  localparam int APB_AW = 12;
  localparam logic [APB_AW-1:0] CTRL_OFFSET = 12'h000;
  localparam logic [APB_AW-1:0] STATUS_OFFSET = 12'h004;

  // control register fields
  localparam int CTRL_HOLD_BIT = 0;
  localparam logic CTRL_HOLD_RESET = 1'b0;

  // status register fields
  localparam int STAT_IE_BIT = 0;
  localparam int STAT_CARRY_BIT = 1;
  localparam int STAT_ZERO_BIT = 2;
  localparam int STAT_SAVED_CARRY_BIT = 3;
  localparam int STAT_SAVED_ZERO_BIT = 4;
  localparam int STAT_IN_ISR_BIT = 5;
  localparam int STAT_SP_LSB = 8;

  // decoded flow operation of the instruction in its execute cycle
  typedef enum logic [2:0] {
    op_seq             = 3'h0,
    op_jump            = 3'h1,
    op_call            = 3'h2,
    op_return          = 3'h3,
    op_return_from_isr = 3'h4,
    op_int_enable      = 3'h5,
    op_int_disable     = 3'h6
  } flow_op_type;

  // condition codes
  typedef enum logic [2:0] {
    cond_always      = 3'h0,
    cond_carry_set   = 3'h1,
    cond_carry_clear = 3'h2,
    cond_zero_set    = 3'h3,
    cond_zero_clear  = 3'h4
  } cond_type;

  typedef struct packed {
    flow_op_type     op;
    cond_type        cond;
    logic            reti_enable;
    logic [PC_W-1:0] target;
  } instr_type;

  typedef struct packed {
    logic carry;
    logic zero;
  } flags_type;

  localparam flags_type FLAGS_RESET = 2'h0;

endpackage

// ---- test/flow_partner_model.sv ----
// instruction store and interrupt source model for the flow sequencer bench
module flow_partner_model (
  input  wire logic                          i_clk,
  input  wire logic                          i_rst,
  input  wire logic [flow_seq_pkg::PC_W-1:0] i_address,
  input  wire logic                          i_execute,
  input  wire logic                          i_ack,
  input  wire logic                          i_raise,
  output flow_seq_pkg::instr_type            o_instr,
  output logic                               o_flags_we,
  output flow_seq_pkg::flags_type            o_alu_flags,
  output logic                               o_interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  flow_seq_pkg::instr_type imem [1024];
  logic [2:0]              side [1024];  // {write enable, carry, zero}

  // outside execute the words are inverted, so an early sample shows up
  assign o_instr     = i_execute ? imem[i_address] : ~imem[i_address];
  assign o_flags_we  = i_execute ? side[i_address][2] : ~side[i_address][2];
  assign o_alu_flags = i_execute ? side[i_address][1:0] : ~side[i_address][1:0];

  task automatic load(input int a, input flow_seq_pkg::flow_op_type op,
                      input flow_seq_pkg::cond_type c, input int en, input int t,
                      input int s);
    imem[a] = '{op, c, en[0], t[flow_seq_pkg::PC_W-1:0]};
    side[a] = s[2:0];
  endtask

  // unloaded locations fall through in sequence
  initial begin
    for (int a = 0; a < 1024; a++) begin
      load(a, flow_seq_pkg::op_seq, flow_seq_pkg::cond_always, 1'b0, 0, 3'h0);
    end
  end

  // request stays latched until acknowledged, so it is held well over two cycles
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_interrupt <= 1'b0;
    else if (i_ack) o_interrupt <= 1'b0;
    else if (i_raise) o_interrupt <= 1'b1;
  end
endmodule

// ---- test/testbench.sv ----
// self-checking bench for the program flow sequencer
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam flow_seq_pkg::flow_op_type JMP = flow_seq_pkg::op_jump;
  localparam flow_seq_pkg::flow_op_type CAL = flow_seq_pkg::op_call;
  localparam flow_seq_pkg::flow_op_type RET = flow_seq_pkg::op_return;
  localparam flow_seq_pkg::cond_type    AL  = flow_seq_pkg::cond_always;
  localparam logic [11:0]               CTL = flow_seq_pkg::CTRL_OFFSET;
  localparam logic [11:0]               STA = flow_seq_pkg::STATUS_OFFSET;
  logic                    i_clk, i_rst, i_psel, i_penable, i_pwrite, raise, we, intr, er;
  logic [11:0]             i_paddr;
  logic [31:0]             i_pwdata, o_prdata, rd;
  logic [9:0]              o_address;
  logic                    o_execute, o_interrupt_ack, o_pready, o_pslverr;
  flow_seq_pkg::instr_type instr;
  flow_seq_pkg::flags_type alu_flags, o_flags;
  int                      err_total, n_tests, acks, cyc;

  program_flow_sequencer i_program_flow_sequencer (.i_clk(i_clk), .i_rst(i_rst),
    .i_instr(instr), .i_flags_we(we), .i_alu_flags(alu_flags), .i_interrupt(intr),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_address(o_address), .o_execute(o_execute),
    .o_interrupt_ack(o_interrupt_ack), .o_flags(o_flags), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr));
  flow_partner_model i_flow_partner_model (.i_clk(i_clk), .i_rst(i_rst), .i_address(o_address),
    .i_execute(o_execute), .i_ack(o_interrupt_ack), .i_raise(raise), .o_instr(instr),
    .o_flags_we(we), .o_alu_flags(alu_flags), .o_interrupt(intr));

  always #2.5 i_clk = ~i_clk;

  task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // wait for the next execute cycle, then check its address and flags
  task exec_at(input logic [9:0] a, input logic [1:0] f);
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      raise <= 1'b0;
      n++;
    end while (o_execute !== 1'b1 && n < 40);
    check(o_execute, 1, "execute cycle");
    check(o_address, a, "program address");
    check(o_flags, f, "flags");
  endtask

  // one apb transfer; the request stands until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= wd;
    @(posedge i_clk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    check(o_pready, 1, "pready");
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  // hang guard: the program needs about a hundred cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      test_done();
    end
  end

  // acknowledge pulse falls in the second of the two non-execute cycles of the event
  always @(posedge i_clk) begin
    if (o_interrupt_ack === 1'b1) begin
      acks++;
      check(o_execute, 0, "ack while executing");
    end
  end

  initial begin
    {i_clk, i_psel, i_penable, i_pwrite, raise, i_paddr, i_pwdata} = '0;
    i_rst = 1'b1;
    {err_total, n_tests, acks, cyc} = '0;
    // wait one edge so the model's own fill cannot overwrite the program
    @(posedge i_clk);
    i_flow_partner_model.load(1, JMP, AL, 0, 1, 0);
    i_flow_partner_model.load(2, flow_seq_pkg::op_seq, AL, 0, 0, 3'h6);
    i_flow_partner_model.load(3, JMP, flow_seq_pkg::cond_carry_clear, 0, 'h100, 0);
    i_flow_partner_model.load(4, JMP, flow_seq_pkg::cond_carry_set, 0, 'h10, 3'h5);
    i_flow_partner_model.load('h10, CAL, flow_seq_pkg::cond_zero_set, 0, 'h200, 0);
    i_flow_partner_model.load('h11, CAL, flow_seq_pkg::cond_zero_clear, 0, 'h200, 3'h5);
    i_flow_partner_model.load('h200, flow_seq_pkg::op_seq, AL, 0, 0, 3'h5);
    i_flow_partner_model.load('h201, RET, flow_seq_pkg::cond_carry_set, 0, 0, 0);
    i_flow_partner_model.load('h202, RET, AL, 0, 0, 3'h6);
    i_flow_partner_model.load('h12, flow_seq_pkg::op_int_enable, AL, 0, 0, 0);
    i_flow_partner_model.load('h3ff, JMP, AL, 0, 'h300, 0);
    i_flow_partner_model.load('h300, flow_seq_pkg::op_seq, AL, 0, 0, 3'h6);
    i_flow_partner_model.load('h301, flow_seq_pkg::op_return_from_isr, AL, 1, 0, 0);
    i_flow_partner_model.load('h14, flow_seq_pkg::op_int_disable, AL, 0, 0, 0);
    i_flow_partner_model.load('h17, flow_seq_pkg::op_int_enable, AL, 0, 0, 0);
    i_flow_partner_model.load('h1b, JMP, AL, 0, 'h1b, 0);
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    exec_at(0, 0);
    exec_at(1, 0);
    // registers while the core spins on a self jump
    apb(0, CTL, 0);
    check(rd, 0, "control reset");
    apb(0, STA, 0);
    check(rd, 0, "status reset");
    apb(1, CTL, 1);
    repeat (4) begin
      @(posedge i_clk);
      check(o_execute, 0, "hold stalls");
    end
    apb(1, CTL, 0);
    apb(0, 12'h008, 0);
    check(er, 1, "unmapped error");
    apb(1, STA, 32'hff);
    apb(0, STA, 0);
    check(rd, 0, "status read only");
    i_flow_partner_model.load(1, JMP, AL, 0, 2, 0);
    exec_at(1, 0);
    exec_at(2, 0);
    exec_at(3, 2'h2);
    exec_at(4, 2'h2);
    exec_at('h10, 2'h2);
    raise <= 1'b1;
    exec_at('h11, 2'h2);
    exec_at('h200, 2'h2);
    exec_at('h201, 2'h1);
    exec_at('h202, 2'h1);
    exec_at('h12, 2'h1);
    exec_at('h13, 2'h1);
    exec_at(flow_seq_pkg::INT_VECTOR, 2'h1);
    exec_at('h300, 2'h1);
    exec_at('h301, 2'h2);
    exec_at('h14, 2'h1);
    raise <= 1'b1;
    exec_at('h15, 2'h1);
    exec_at('h16, 2'h1);
    exec_at('h17, 2'h1);
    i_flow_partner_model.load('h301, flow_seq_pkg::op_return_from_isr, AL, 0, 0, 0);
    exec_at('h18, 2'h1);
    exec_at(flow_seq_pkg::INT_VECTOR, 2'h1);
    exec_at('h300, 2'h1);
    exec_at('h301, 2'h2);
    exec_at('h19, 2'h1);
    raise <= 1'b1;
    exec_at('h1a, 2'h1);
    exec_at('h1b, 2'h1);
    apb(0, STA, 0);
    check(rd, 32'h14, "status after return");
    check(acks, 2, "ack count");
    test_done();
  end
endmodule
